// ### common/rsad_consts.svh
/*
 * Named constants of the radio serial access decoder: header layout,
 * address map, strobe codes, radio state codes and status byte fields.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef RSAD_CONSTS_SVH
`define RSAD_CONSTS_SVH

// ============================================================
// header byte layout
`define RSAD_HDR_RW 7
`define RSAD_HDR_BURST 6
`define RSAD_ADDR_W 6

// ============================================================
// address map
`define RSAD_STROBE_LO 6'h30
`define RSAD_STROBE_HI 6'h3d
`define RSAD_ADDR_PA 6'h3e
`define RSAD_ADDR_FIFO 6'h3f

// ============================================================
// strobe codes inside the strobe range
`define RSAD_STB_RESET 6'h30
`define RSAD_STB_XOFF 6'h32
`define RSAD_STB_RX 6'h34
`define RSAD_STB_TX 6'h35
`define RSAD_STB_IDLE 6'h36
`define RSAD_STB_PWD 6'h39
`define RSAD_STB_FRX 6'h3a
`define RSAD_STB_FTX 6'h3b

// ============================================================
// main radio state codes as reported in the status byte
`define RSAD_ST_IDLE 3'h0
`define RSAD_ST_RX 3'h1
`define RSAD_ST_TX 3'h2
`define RSAD_ST_RXOVF 3'h6
`define RSAD_ST_TXUNF 3'h7

// ============================================================
// status byte and power table
`define RSAD_CNT_CAP 4'hf
`define RSAD_PA_ENTRIES 8
`define RSAD_PA_IDX_W 3
`define RSAD_FIFO_DEPTH 64

`endif

// ### common/rsad_pkg.sv
/*
 * Types shared by the radio serial access decoder: access kinds and the
 * state record of the serial-clock side.
 * Assumes rsad_consts.svh is reachable on the include path.
 */
`include "rsad_consts.svh"

package rsad_pkg;

    // ============================================================
    // kind of access opened by the last header byte
    typedef enum logic [3:0] {
        RSAD_ACC_REG = 4'b0001,
        RSAD_ACC_FIFO = 4'b0010,
        RSAD_ACC_PA = 4'b0100,
        RSAD_ACC_STAT = 4'b1000
    } rsad_acc_t;

    // ============================================================
    // state clocked by the serial clock
    typedef struct packed {
        logic [2:0] cnt;
        logic fb;
        logic [6:0] sh;
        logic [7:0] byte_q;
        logic tgl;
    } rsad_link_t;

endpackage : rsad_pkg

// ### verilog/rsad_access_decoder.sv
/*
 * Serial access decoder of a sub-GHz radio: shifts header and data bytes
 * in on the serial clock, decodes strobes, FIFO, power table and register
 * accesses on the system clock, returns status or read data on the
 * shared output pin and handles three-pin radio control.
 * Assumes the radio state machine, configuration registers and pin pads
 * sit outside; the serial clock stands still while select is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsad_consts.svh"

// How it works
// - strobe range with burst set reads a status register, else strobe
// - status register reads are single byte only, header follows again
// - strobe is one header byte; its rw bit picks the count meaning
// - status byte shifts out while any header byte shifts in
// - strobes run at once; power-down and crystal-off wait for select high
// - address 0x3f reaches transmit FIFO on write, receive FIFO on read
// - transmit FIFO only takes writes, receive FIFO only gives reads
// - single FIFO access is one data byte; burst runs until select high
// - FIFO headers 0x3f, 0x7f, 0xbf, 0xff all decode as one kind, FIFO
// - transmit writes report free count before the byte is stored
// - FIFO flush strobes act only in idle, underflow or overflow
// - entering sleep empties both FIFOs
// - address 0x3e opens the power table, burst bytes follow until select high
// - power table holds eight bytes, the power index picks one
// - table index steps per byte, wraps at 7, clears while select high
// - table access single or burst, read or write by header bits
// - entering sleep clears table entries except index 0
// - shared pin tri-states by default, serial out while select low
// - in serial modes pin zero is the transmit data input during TX
// - with pin control, select fall latches clock and data as strobe
// - pin codes clock,data: 00 power-down, 01 TX, 10 idle, 11 RX
// - pin control only changes state; power-down waits for select high
// - status byte: ready low bit 7, state bits 6:4, count bits 3:0
module rsad_access_decoder
    import rsad_pkg::*;
#(
    parameter int FIFO_DEPTH = `RSAD_FIFO_DEPTH
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic SPI_CLK_I,
    input wire logic SELECT_LOW_PIN_N_I,
    input wire logic SPI_DATA_I,
    output logic GENERAL_OUT_SHARED_O,
    output logic GENERAL_OUT_SHARED_OE_O,
    input wire logic SHARED_GENERIC_EN_I,
    input wire logic SHARED_STATUS_I,
    input wire logic GENERAL_OUT_ZERO_I,
    output logic GENERAL_OUT_ZERO_O,
    output logic GENERAL_OUT_ZERO_OE_O,
    input wire logic ZERO_STATUS_I,
    input wire logic SERIAL_MODE_I,
    output logic SERIAL_TX_DATA_O,
    input wire logic [2:0] RADIO_STATE_I,
    input wire logic XTAL_READY_I,
    input wire logic SLEEP_ENTRY_I,
    input wire logic PIN_CONTROL_ENABLE_I,
    input wire logic [2:0] POWER_INDEX_SELECT_I,
    output logic [7:0] PA_SETTING_O,
    output logic STROBE_O,
    output logic [5:0] STROBE_CODE_O,
    output logic [5:0] REG_ADDR_O,
    output logic [7:0] REG_WDATA_O,
    output logic REG_WRITE_O,
    input wire logic [7:0] REG_RDATA_I,
    output logic [7:0] TX_DATA_O,
    output logic TX_VALID_O,
    input wire logic TX_READY_I,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_VALID_I,
    output logic RX_READY_O
);

    localparam int AW = $clog2(FIFO_DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(FIFO_DEPTH);

    typedef struct packed {
        logic cs_m;
        logic cs_s;
        logic cs_p;
        logic tg_m;
        logic tg_m2;
        logic tg_s;
        logic tg_ref;
        logic ck_m;
        logic ck_s;
        logic si_m;
        logic si_s;
        logic g0_m;
        logic g0_s;
        logic hdr;
        logic rw;
        logic burst;
        rsad_acc_t acc;
        logic [5:0] addr;
        logic [2:0] pa_idx;
        logic pend_pwd;
        logic pend_xoff;
        logic stb;
        logic [5:0] stb_code;
        logic reg_wr;
        logic [7:0] reg_wdata;
        logic [7:0] stat_rd;
        logic [7:0] stat_wr;
        logic [7:0] out_word;
        logic [7:0] pa_out;
        logic shared_o;
        logic shared_oe;
        logic zero_o;
        logic zero_oe;
        logic ser_tx;
        logic [`RSAD_PA_ENTRIES-1:0][7:0] pa;
        logic [FIFO_DEPTH-1:0][7:0] txm;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [AW:0] tx_cnt;
        logic [FIFO_DEPTH-1:0][7:0] rxm;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [AW:0] rx_cnt;
    } rsad_sys_t;

    rsad_link_t l_q;
    rsad_link_t l_d;
    rsad_sys_t s_q;
    rsad_sys_t s_d;

    // ============================================================
    // serial clock side: bytes in, toggle out
    always_comb begin
        l_d = l_q;
        if (l_q.cnt == 3'h0) begin
            l_d.fb = SPI_DATA_I;
        end
        l_d.sh = {l_q.sh[5:0], SPI_DATA_I};
        l_d.cnt = l_q.cnt + 3'h1;
        if (l_q.cnt == 3'h7) begin
            l_d.byte_q = {l_q.sh, SPI_DATA_I};
            l_d.tgl = ~l_q.tgl;
        end
    end

    // select high clears the bit count, so a cut byte never shifts on
    always_ff @(posedge SPI_CLK_I or posedge SELECT_LOW_PIN_N_I) begin
        if (SELECT_LOW_PIN_N_I) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // ============================================================
    // system clock side
    function automatic logic [3:0] rsad_cap(input logic [AW:0] n);
        rsad_cap = (n > (AW + 1)'(`RSAD_CNT_CAP)) ? `RSAD_CNT_CAP : n[3:0];
    endfunction : rsad_cap

    always_comb begin
        logic evt;
        logic [7:0] b;
        logic in_stb;
        logic tx_push;
        logic tx_pop;
        logic rx_push;
        logic rx_pop;
        logic tx_fl;
        logic rx_fl;
        logic flush_ok;
        evt = 1'b0;
        b = l_q.byte_q;
        in_stb = 1'b0;
        tx_push = 1'b0;
        tx_pop = TX_VALID_O && TX_READY_I;
        rx_push = RX_VALID_I && RX_READY_O;
        rx_pop = 1'b0;
        tx_fl = 1'b0;
        rx_fl = 1'b0;
        s_d = s_q;
        // pins and the byte toggle cross through flip-flop chains;
        // the toggle takes one stage more than select so the edge made
        // by the select-high clear is always seen after select
        s_d.cs_m = SELECT_LOW_PIN_N_I;
        s_d.cs_s = s_q.cs_m;
        s_d.cs_p = s_q.cs_s;
        s_d.tg_m = l_q.tgl;
        s_d.tg_m2 = s_q.tg_m;
        s_d.tg_s = s_q.tg_m2;
        s_d.tg_ref = s_q.tg_s;
        s_d.ck_m = SPI_CLK_I;
        s_d.ck_s = s_q.ck_m;
        s_d.si_m = SPI_DATA_I;
        s_d.si_s = s_q.si_m;
        s_d.g0_m = GENERAL_OUT_ZERO_I;
        s_d.g0_s = s_q.g0_m;
        s_d.stb = 1'b0;
        s_d.reg_wr = 1'b0;
        flush_ok = (RADIO_STATE_I == `RSAD_ST_IDLE) ||
                   (RADIO_STATE_I == `RSAD_ST_TXUNF) ||
                   (RADIO_STATE_I == `RSAD_ST_RXOVF);
        evt = (s_q.tg_s != s_q.tg_ref) && !s_q.cs_s;

        if (s_q.cs_s) begin
            s_d.hdr = 1'b1;
            s_d.pa_idx = 3'h0;
            // deferred strobes fire once select is high, one per cycle
            if (s_q.pend_xoff) begin
                s_d.pend_xoff = 1'b0;
                s_d.stb = 1'b1;
                s_d.stb_code = `RSAD_STB_XOFF;
            end else if (s_q.pend_pwd) begin
                s_d.pend_pwd = 1'b0;
                s_d.stb = 1'b1;
                s_d.stb_code = `RSAD_STB_PWD;
            end
        end

        // three-pin control latched at the select fall
        if (s_q.cs_p && !s_q.cs_s && PIN_CONTROL_ENABLE_I) begin
            unique case ({s_q.ck_s, s_q.si_s})
                2'b00: s_d.pend_pwd = 1'b1;
                2'b01: begin
                    s_d.stb = (RADIO_STATE_I != `RSAD_ST_TX);
                    s_d.stb_code = `RSAD_STB_TX;
                end
                2'b10: begin
                    s_d.stb = (RADIO_STATE_I != `RSAD_ST_IDLE);
                    s_d.stb_code = `RSAD_STB_IDLE;
                end
                2'b11: begin
                    s_d.stb = (RADIO_STATE_I != `RSAD_ST_RX);
                    s_d.stb_code = `RSAD_STB_RX;
                end
            endcase
        end

        if (evt && s_q.hdr) begin
            s_d.rw = b[`RSAD_HDR_RW];
            s_d.burst = b[`RSAD_HDR_BURST];
            s_d.addr = b[`RSAD_ADDR_W-1:0];
            in_stb = (b[5:0] >= `RSAD_STROBE_LO) &&
                     (b[5:0] <= `RSAD_STROBE_HI);
            if (in_stb && !b[`RSAD_HDR_BURST]) begin
                if (b[5:0] == `RSAD_STB_PWD) begin
                    s_d.pend_pwd = 1'b1;
                end else if (b[5:0] == `RSAD_STB_XOFF) begin
                    s_d.pend_xoff = 1'b1;
                end else begin
                    s_d.stb = 1'b1;
                    s_d.stb_code = b[5:0];
                end
                tx_fl = (b[5:0] == `RSAD_STB_FTX) && flush_ok;
                rx_fl = (b[5:0] == `RSAD_STB_FRX) && flush_ok;
            end else begin
                s_d.hdr = 1'b0;
                if (b[5:0] == `RSAD_ADDR_FIFO) begin
                    s_d.acc = RSAD_ACC_FIFO;
                end else if (b[5:0] == `RSAD_ADDR_PA) begin
                    s_d.acc = RSAD_ACC_PA;
                end else if (in_stb) begin
                    s_d.acc = RSAD_ACC_STAT;
                end else begin
                    s_d.acc = RSAD_ACC_REG;
                end
            end
        end else if (evt) begin
            unique case (s_q.acc)
                RSAD_ACC_FIFO: begin
                    tx_push = !s_q.rw && (s_q.tx_cnt < DEPTH_C);
                    rx_pop = s_q.rw && (s_q.rx_cnt != '0);
                end
                RSAD_ACC_PA: begin
                    if (!s_q.rw) begin
                        s_d.pa[s_q.pa_idx] = b;
                    end
                    s_d.pa_idx = s_q.pa_idx + 3'h1;
                end
                RSAD_ACC_REG: begin
                    s_d.reg_wr = !s_q.rw;
                    s_d.reg_wdata = b;
                    if (s_q.burst) begin
                        s_d.addr = s_q.addr + 6'h01;
                    end
                end
                RSAD_ACC_STAT: ;
            endcase
            // single access ends after one byte; status never bursts
            if (!s_q.burst || s_q.acc == RSAD_ACC_STAT) begin
                s_d.hdr = 1'b1;
            end
        end

        if (SLEEP_ENTRY_I) begin
            tx_fl = 1'b1;
            rx_fl = 1'b1;
            for (int i = 1; i < `RSAD_PA_ENTRIES; i++) begin
                s_d.pa[i] = 8'h00;
            end
        end

        // transmit FIFO: written over the serial port, drained by radio
        if (tx_push) begin
            s_d.txm[s_q.tx_wp] = b;
            s_d.tx_wp = s_q.tx_wp + AW'(1);
        end
        if (tx_pop) begin
            s_d.tx_rp = s_q.tx_rp + AW'(1);
        end
        s_d.tx_cnt = s_q.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
        if (tx_fl) begin
            s_d.tx_wp = '0;
            s_d.tx_rp = '0;
            s_d.tx_cnt = '0;
        end
        // receive FIFO: filled by radio, read over the serial port
        if (rx_push) begin
            s_d.rxm[s_q.rx_wp] = RX_DATA_I;
            s_d.rx_wp = s_q.rx_wp + AW'(1);
        end
        if (rx_pop) begin
            s_d.rx_rp = s_q.rx_rp + AW'(1);
        end
        s_d.rx_cnt = s_q.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
        if (rx_fl) begin
            s_d.rx_wp = '0;
            s_d.rx_rp = '0;
            s_d.rx_cnt = '0;
        end

        // status words follow the live counts, so a transmit write sees
        // the free count before its own byte is stored
        s_d.stat_rd = {~XTAL_READY_I, RADIO_STATE_I,
                       rsad_cap(s_d.rx_cnt)};
        s_d.stat_wr = {~XTAL_READY_I, RADIO_STATE_I,
                       rsad_cap(DEPTH_C - s_d.tx_cnt)};
        s_d.out_word = s_d.stat_wr;
        if (!s_d.hdr && s_d.rw) begin
            unique case (s_d.acc)
                RSAD_ACC_FIFO: s_d.out_word = s_d.rxm[s_d.rx_rp];
                RSAD_ACC_PA: s_d.out_word = s_d.pa[s_d.pa_idx];
                RSAD_ACC_REG: s_d.out_word = REG_RDATA_I;
                RSAD_ACC_STAT: s_d.out_word = REG_RDATA_I;
            endcase
        end
        s_d.pa_out = s_d.pa[POWER_INDEX_SELECT_I];

        // general pins; shared pin idles tri-stated until made generic
        s_d.shared_o = SHARED_STATUS_I;
        s_d.shared_oe = SHARED_GENERIC_EN_I;
        s_d.zero_oe = !(SERIAL_MODE_I && RADIO_STATE_I == `RSAD_ST_TX);
        s_d.zero_o = ZERO_STATUS_I;
        s_d.ser_tx = s_q.g0_s;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            s_q <= '0;
            s_q.cs_m <= 1'b1;
            s_q.cs_s <= 1'b1;
            s_q.cs_p <= 1'b1;
            s_q.hdr <= 1'b1;
            s_q.acc <= RSAD_ACC_REG;
            s_q.stat_rd <= 8'h80;
            s_q.stat_wr <= 8'h80;
            s_q.out_word <= 8'h80;
            s_q.zero_oe <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // outputs
    logic so_bit;

    // the bit index follows the serial clock; the word is held steady
    // by the system side for most of a byte, limiting the clock ratio
    always_comb begin
        so_bit = s_q.out_word[~l_q.cnt];
        if (s_q.hdr) begin
            so_bit = l_q.fb ? s_q.stat_rd[~l_q.cnt] :
                              s_q.stat_wr[~l_q.cnt];
        end
    end

    assign GENERAL_OUT_SHARED_O = SELECT_LOW_PIN_N_I ? s_q.shared_o : so_bit;
    assign GENERAL_OUT_SHARED_OE_O = !SELECT_LOW_PIN_N_I ||
                                     s_q.shared_oe;
    assign GENERAL_OUT_ZERO_O = s_q.zero_o;
    assign GENERAL_OUT_ZERO_OE_O = s_q.zero_oe;
    assign SERIAL_TX_DATA_O = s_q.ser_tx;
    assign PA_SETTING_O = s_q.pa_out;
    assign STROBE_O = s_q.stb;
    assign STROBE_CODE_O = s_q.stb_code;
    assign REG_ADDR_O = s_q.addr;
    assign REG_WDATA_O = s_q.reg_wdata;
    assign REG_WRITE_O = s_q.reg_wr;
    assign TX_DATA_O = s_q.txm[s_q.tx_rp];
    assign TX_VALID_O = (s_q.tx_cnt != '0);
    assign RX_READY_O = (s_q.rx_cnt < DEPTH_C);

endmodule : rsad_access_decoder

`default_nettype wire

// ### verif/rsad_assertions.sv
/*
 * Checker of the access decoder: shared pin drive, pin zero direction,
 * strobe pulses, deferred strobes and sleep flush.
 * Assumes it is bound to the decoder top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module rsad_assertions (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic SELECT_LOW_PIN_N_I,
    input wire logic GENERAL_OUT_SHARED_O,
    input wire logic GENERAL_OUT_SHARED_OE_O,
    input wire logic SHARED_GENERIC_EN_I,
    input wire logic SHARED_STATUS_I,
    input wire logic GENERAL_OUT_ZERO_I,
    input wire logic GENERAL_OUT_ZERO_OE_O,
    input wire logic SERIAL_MODE_I,
    input wire logic SERIAL_TX_DATA_O,
    input wire logic [2:0] RADIO_STATE_I,
    input wire logic SLEEP_ENTRY_I,
    input wire logic STROBE_O,
    input wire logic [5:0] STROBE_CODE_O,
    input wire logic TX_VALID_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);
    // ========
    // pins
    property p_sod;
        !SELECT_LOW_PIN_N_I |-> GENERAL_OUT_SHARED_OE_O;
    endproperty
    a_sod: assert property (p_sod)
        else $error("shared pin undriven");
    property p_soz;
        (SELECT_LOW_PIN_N_I && !SHARED_GENERIC_EN_I)[*4]
            |-> !GENERAL_OUT_SHARED_OE_O;
    endproperty
    a_soz: assert property (p_soz)
        else $error("pin driven idle");
    property p_sov;
        SELECT_LOW_PIN_N_I[*4] |-> GENERAL_OUT_SHARED_O == $past(SHARED_STATUS_I);
    endproperty
    a_sov: assert property (p_sov)
        else $error("pin status wrong");
    property p_zoe;
        !$past(RESET_I) |-> GENERAL_OUT_ZERO_OE_O
            == !($past(SERIAL_MODE_I) && $past(RADIO_STATE_I) == 3'h2);
    endproperty
    a_zoe: assert property (p_zoe)
        else $error("zero dir wrong");
    property p_ztx;
        !$past(RESET_I) && !$past(RESET_I, 2) && !$past(RESET_I, 3)
            |-> SERIAL_TX_DATA_O == $past(GENERAL_OUT_ZERO_I, 3);
    endproperty
    a_ztx: assert property (p_ztx)
        else $error("tx data wrong");
    // ========
    // strobes and sleep
    property p_stb;
        STROBE_O |-> (STROBE_CODE_O >= 6'h30 && STROBE_CODE_O <= 6'h3d)
            ##1 !STROBE_O;
    endproperty
    a_stb: assert property (p_stb)
        else $error("strobe pulse wrong");
    property p_dly;
        STROBE_O && (STROBE_CODE_O == 6'h39 || STROBE_CODE_O == 6'h32)
            |-> SELECT_LOW_PIN_N_I && $past(SELECT_LOW_PIN_N_I);
    endproperty
    a_dly: assert property (p_dly)
        else $error("early strobe");
    property p_slp;
        SLEEP_ENTRY_I |-> ##[1:4] !TX_VALID_O;
    endproperty
    a_slp: assert property (p_slp)
        else $error("sleep left tx data");
endmodule : rsad_assertions
`default_nettype wire

// ### verif/rsad_host_model.sv
/*
 * Host model: serial master.
 * Assumes its tasks are called just after a sys clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module rsad_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    // ========
    // frames; long select high so the sys side sees every edge
    task automatic sel();
        cs_n_o = 1'b0;
        #40;
    endtask : sel
    task automatic desel();
        cs_n_o = 1'b1;
        #60;
    endtask : desel
    // gap covers the first data bit race
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            #7.5;
            rx[i] = so_i;
            sclk_o = 1'b1;
            #7.5;
            sclk_o = 1'b0;
        end
        si_o = ~si_o;
        #45;
    endtask : xfer
    task automatic pinsel(input logic c, input logic d);
        sclk_o = c;
        si_o = d;
        #30;
        cs_n_o = 1'b0;
        #40;
        cs_n_o = 1'b1;
        #10;
        sclk_o = 1'b0;
        si_o = ~d;
        #50;
    endtask : pinsel
endmodule : rsad_host_model
`default_nettype wire

// ### verif/rsad_testbench.sv
/*
 * Self-checking bench of the radio serial access decoder.
 * Assumes the design, host model and checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst = 1'b1, sclk, cs_n, si, so_o, so_oe, z_o, z_oe, ser_tx;
    logic gen_en = 1'b0, sh_st = 1'b0, z_in = 1'b0, z_st = 1'b0, ser = 1'b0;
    logic xtal = 1'b1, slp = 1'b0, pce = 1'b0, txr = 1'b0, rxv = 1'b0;
    logic stb, txv, rxr, dfr;
    logic [2:0] st = 3'h0, pidx = 3'h0;
    logic [5:0] scode, raddr;
    logic [7:0] pa, txd, rxd = 8'h00, r;
    logic [5:0] log_q[$];
    logic [5:0] codes[8] = '{6'h30, 6'h32, 6'h34, 6'h35, 6'h36, 6'h39,
                             6'h3a, 6'h3b};
    logic [5:0] pcode[4] = '{6'h39, 6'h35, 6'h36, 6'h34};
    logic [2:0] fst[4] = '{3'h1, 3'h0, 3'h7, 3'h6};
    int err_count = 0, cmp_count = 0;
    wire logic so_w;
    assign so_w = so_oe ? so_o : 1'bz;
    rsad_access_decoder u_dut (
        .SYS_CLK_I(clk), .RESET_I(rst), .SPI_CLK_I(sclk),
        .SELECT_LOW_PIN_N_I(cs_n), .SPI_DATA_I(si),
        .GENERAL_OUT_SHARED_O(so_o), .GENERAL_OUT_SHARED_OE_O(so_oe),
        .SHARED_GENERIC_EN_I(gen_en), .SHARED_STATUS_I(sh_st),
        .GENERAL_OUT_ZERO_I(z_in), .GENERAL_OUT_ZERO_O(z_o),
        .GENERAL_OUT_ZERO_OE_O(z_oe), .ZERO_STATUS_I(z_st),
        .SERIAL_MODE_I(ser), .SERIAL_TX_DATA_O(ser_tx),
        .RADIO_STATE_I(st), .XTAL_READY_I(xtal), .SLEEP_ENTRY_I(slp),
        .PIN_CONTROL_ENABLE_I(pce), .POWER_INDEX_SELECT_I(pidx),
        .PA_SETTING_O(pa), .STROBE_O(stb), .STROBE_CODE_O(scode),
        .REG_ADDR_O(raddr), .REG_WDATA_O(), .REG_WRITE_O(),
        .REG_RDATA_I(8'h5c), .TX_DATA_O(txd), .TX_VALID_O(txv),
        .TX_READY_I(txr), .RX_DATA_I(rxd), .RX_VALID_I(rxv),
        .RX_READY_O(rxr)
    );
    rsad_host_model u_host (
        .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_w)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (stb === 1'b1) log_q.push_back(scode);
    // ========
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // 6'h00 means no strobe expected since the last call
    task automatic logged(input logic [5:0] c);
        chk(9'(log_q.size()), (c == 6'h00) ? 9'h0 : 9'h1);
        if (log_q.size() == 1) chk({3'h0, log_q[0]}, {3'h0, c});
        log_q.delete();
    endtask : logged
    task automatic pa_read(input logic [7:0] e0, input logic kept);
        logic [7:0] v;
        u_host.sel();
        u_host.xfer(8'hfe, v);
        chk({1'b0, v}, 9'h000);
        for (int k = 0; k < 8; k++) begin
            u_host.xfer(8'h00, v);
            chk({1'b0, v}, {1'b0, (k == 0) ? e0 : (kept ? 8'h30 | 8'(k) : 8'h00)});
        end
        u_host.desel();
    endtask : pa_read
    task automatic give_verdict();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    // ========
    // tests
    initial begin
        step(6);
        rst = 1'b0;
        step(4);
        foreach (codes[k]) begin
            xtal = (codes[k] != 6'h30);
            dfr = codes[k] == 6'h39 || codes[k] == 6'h32;
            u_host.sel();
            u_host.xfer({2'b00, codes[k]}, r);
            chk({1'b0, r}, {1'b0, ~xtal, 3'h0, 4'hf});
            step(8);
            logged(dfr ? 6'h00 : codes[k]);
            u_host.desel();
            logged(dfr ? codes[k] : 6'h00);
        end
        xtal = 1'b1;
        $display("test strobes done");
        u_host.sel();
        u_host.xfer(8'hf5, r);
        chk({3'h0, raddr}, 9'h035);
        u_host.xfer(8'h00, r);
        chk({1'b0, r}, 9'h05c);
        u_host.desel();
        logged(6'h00);
        $display("test status read done");
        u_host.sel();
        u_host.xfer(8'h7f, r);
        chk({1'b0, r}, 9'h00f);
        for (int i = 0; i < 64; i++) begin
            u_host.xfer(8'(i * 3 + 1), r);
            chk({1'b0, r}, {5'h0, (i > 49) ? 4'(64 - i) : 4'hf});
        end
        u_host.desel();
        txr = 1'b1;
        for (int i = 0; i < 64; i++) begin
            chk({txv, txd}, {1'b1, 8'(i * 3 + 1)});
            step(1);
        end
        chk({8'h0, txv}, 9'h000);
        txr = 1'b0;
        $display("test tx burst done");
        rxv = 1'b1;
        for (int i = 0; i < 3; i++) begin
            rxd = 8'hc1 + 8'(i);
            step(1);
        end
        rxv = 1'b0;
        u_host.sel();
        u_host.xfer(8'hbf, r);
        chk({1'b0, r}, 9'h003);
        u_host.xfer(8'h00, r);
        chk({1'b0, r}, 9'h0c1);
        u_host.xfer(8'hff, r);
        chk({1'b0, r}, 9'h002);
        u_host.xfer(8'h00, r);
        chk({1'b0, r}, 9'h0c2);
        u_host.xfer(8'h00, r);
        chk({1'b0, r}, 9'h0c3);
        u_host.desel();
        $display("test rx read done");
        u_host.sel();
        u_host.xfer(8'h7e, r);
        for (int i = 0; i < 9; i++) u_host.xfer(8'h30 + 8'(i), r);
        u_host.desel();
        pidx = 3'h3;
        step(2);
        chk({1'b0, pa}, 9'h033);
        pa_read(8'h38, 1'b1);
        rxv = 1'b1;
        rxd = 8'h77;
        step(1);
        rxv = 1'b0;
        u_host.sel();
        u_host.xfer(8'h3f, r);
        u_host.xfer(8'h99, r);
        u_host.desel();
        chk({8'h0, txv}, 9'h001);
        slp = 1'b1;
        step(1);
        slp = 1'b0;
        step(4);
        chk({7'h0, txv, rxr}, 9'h001);
        pa_read(8'h38, 1'b0);
        chk({1'b0, pa}, 9'h000);
        $display("test power table done");
        foreach (fst[k]) begin
            u_host.sel();
            u_host.xfer(8'h3f, r);
            u_host.xfer(8'h5a, r);
            st = fst[k];
            u_host.xfer(8'h3b, r);
            chk({1'b0, r}, {2'b0, fst[k], 4'hf});
            step(8);
            chk({8'h0, txv}, {8'h0, k == 0});
            u_host.desel();
        end
        log_q.delete();
        $display("test flush done");
        pce = 1'b1;
        st = 3'h3;
        foreach (pcode[k]) begin
            u_host.pinsel(k[1], k[0]);
            step(4);
            logged(pcode[k]);
        end
        st = 3'h2;
        u_host.pinsel(1'b0, 1'b1);
        step(4);
        logged(6'h00);
        pce = 1'b0;
        $display("test pin control done");
        gen_en = 1'b1;
        sh_st = 1'b1;
        z_st = 1'b1;
        ser = 1'b1;
        z_in = 1'b1;
        step(5);
        chk({5'h0, so_oe, so_o, z_oe, z_o}, 9'h00d);
        chk({8'h0, ser_tx}, 9'h001);
        gen_en = 1'b0;
        step(3);
        chk({8'h0, so_oe}, 9'h000);
        $display("test pins done");
        give_verdict();
    end
endmodule : testbench
bind rsad_access_decoder rsad_assertions u_chk (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
    .SELECT_LOW_PIN_N_I(SELECT_LOW_PIN_N_I),
    .GENERAL_OUT_SHARED_O(GENERAL_OUT_SHARED_O),
    .GENERAL_OUT_SHARED_OE_O(GENERAL_OUT_SHARED_OE_O),
    .SHARED_GENERIC_EN_I(SHARED_GENERIC_EN_I),
    .SHARED_STATUS_I(SHARED_STATUS_I),
    .GENERAL_OUT_ZERO_I(GENERAL_OUT_ZERO_I),
    .GENERAL_OUT_ZERO_OE_O(GENERAL_OUT_ZERO_OE_O),
    .SERIAL_MODE_I(SERIAL_MODE_I), .SERIAL_TX_DATA_O(SERIAL_TX_DATA_O),
    .RADIO_STATE_I(RADIO_STATE_I), .SLEEP_ENTRY_I(SLEEP_ENTRY_I),
    .STROBE_O(STROBE_O), .STROBE_CODE_O(STROBE_CODE_O),
    .TX_VALID_O(TX_VALID_O)
);
`default_nettype wire
